// [rtl/clsl_top.sv]
// Purpose: Digital side of a chainable three-channel LED sink driver
// Assumes: Link clock stops between frames; rst is on the system clock
// Notes: The shift register lives on the link clock; latch and gate on clk
// Operation
// [R1] Gate low enables channels; gate high blanks every channel.
// [R2] Strobe high makes the latch follow the shift register.
// [R3] Strobe falling holds the latch until strobe rises again; words already buffered still reach the latch.
// [R4] Shift register advances one place on each rising link clock edge.
// [R5] Serial input feeds the shift register; upstream holds it valid.
// [R6] Serial output changes only on falling link clock edges.
// [R7] Each serial output wires to the next driver's serial input.
// [R8] Clock repeat output reproduces the incoming link clock.
// [R9] Strobe repeat output reproduces the incoming latch strobe.
// [R10] Gate repeat output reproduces the incoming active-low gate.
// [R11] Three sink channels, red, green, blue, set by latch and gate.
// [R12] Link works up to 5 MHz over two metres of cable.
// [R13] Controller shifts all data with strobe low, then pulses it once.
`timescale 1ns/1ps
module clsl_top
    import clsl_pkg::*;
#(
    parameter int SR_LEN = SR_LEN_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic gate_n,
    input wire logic latch_hold,
    output logic serial_out,
    output logic clock_repeat,
    output logic strobe_repeat,
    output logic gate_repeat_n,
    output logic [CHAN_NUM-1:0] current_sink_channels
);
    ////////////////////////////////////////////////////////////////////////
    // Link domain: reset crossing and shift register
    // Link clock stops between frames, so reset needs link edges

    logic lrst;
    logic [SR_LEN-1:0] sr_q;
    logic [SR_LEN-1:0] sr_d;
    logic sout_q;
    logic rise_tgl_q;
    logic fall_tgl_q;

    // Reset carried into the link domain; needs a few link edges
    clsl_sync #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_lrst (
        .clk(link_clk),
        .rst(1'b0),
        .din(rst),
        .dout(lrst)
    );

    // [R4] Shift on rising edge
    // [R5] New bit enters at the low end
    always_comb
    begin
        sr_d = {sr_q[SR_LEN-2:0], serial_in};
    end

    // Serial input is launched by upstream on its falling edge,
    // so it is stable here and needs no synchroniser
    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            sr_q <= '0;
            rise_tgl_q <= 1'b0;
        end
        else
        begin
            sr_q <= sr_d;
            rise_tgl_q <= ~rise_tgl_q;
        end
    end

    // [R6] Output moves on falling edge, half a period early for next stage
    always_ff @(negedge link_clk)
    begin
        if (lrst)
        begin
            sout_q <= 1'b0;
            fall_tgl_q <= 1'b0;
        end
        else
        begin
            sout_q <= sr_q[SR_LEN-1];
            fall_tgl_q <= rise_tgl_q;
        end
    end

    // [R7] Top bit leaves through the serial output
    assign serial_out = sout_q;
    // [R8] High after a rising edge, low after a falling edge
    // One flop per edge; XOR is the only way to rebuild the clock
    assign clock_repeat = rise_tgl_q ^ fall_tgl_q;

    ////////////////////////////////////////////////////////////////////////
    // Crossings into the system clock

    logic [SR_LEN-1:0] word_s;
    logic strobe_s;
    logic gate_s;

    // Word is quasi-static between frames; checked for stability below
    clsl_sync #(
        .W(SR_LEN),
        .RST_VAL('0)
    ) u_word (
        .clk(clk),
        .rst(rst),
        .din(sr_q),
        .dout(word_s)
    );

    // Control pins as plain levels
    clsl_sync #(
        .W(2),
        .RST_VAL({STROBE_RST, GATE_RST})
    ) u_ctrl (
        .clk(clk),
        .rst(rst),
        .din({latch_strobe, gate_n}),
        .dout({strobe_s, gate_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // System domain state

    typedef struct packed {
        logic [SR_LEN-1:0] prev;
        logic [STAB_W-1:0] stab;
        logic [SR_LEN-1:0] sent;
        logic [SR_LEN-1:0] latch;
        logic [CHAN_NUM-1:0] chan;
        logic strobe_rep;
        logic gate_rep;
    } clsl_state_t;

    localparam logic [STAB_W-1:0] STAB_MAX = STAB_W'(STABLE_CYC);

    clsl_state_t st_q;
    clsl_state_t st_d;
    logic word_ok;
    logic push_valid;
    logic push_ready;
    logic pop_valid;
    logic pop_ready;
    logic [SR_LEN-1:0] pop_data;

    // [R12] Settle time sized for the fastest link clock
    // Word trusted only after it has held still for the settle time
    assign word_ok = (st_q.stab == STAB_MAX) && (word_s == st_q.prev);
    // [R2] Offer every new stable word while strobe is high
    assign push_valid = strobe_s && word_ok && (word_s != st_q.sent);
    // Drain stalls while the system holds the latch
    // A stall only delays the latch; the buffer keeps both words
    assign pop_ready = ~latch_hold;

    clsl_buf #(
        .W(SR_LEN),
        .DEPTH(2)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(word_s),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_data)
    );

    // Next state of the system domain
    always_comb
    begin
        st_d = st_q;
        st_d.prev = word_s;
        if (word_s != st_q.prev)
        begin
            st_d.stab = '0;
        end
        else if (st_q.stab != STAB_MAX)
        begin
            st_d.stab = st_q.stab + 1'b1;
        end
        if (push_valid && push_ready)
        begin
            st_d.sent = word_s;
        end
        // [R3] Latch only moves on buffered words, none offered once low
        if (pop_valid && pop_ready)
        begin
            st_d.latch = pop_data;
        end
        // [R1] Blank all channels while the gate is high
        // [R11] Each channel follows its latched bit
        if (gate_s)
        begin
            st_d.chan = '0;
        end
        else
        begin
            st_d.chan = st_q.latch[CHAN_NUM-1:0];
        end
        // [R9] Strobe replica
        st_d.strobe_rep = strobe_s;
        // [R10] Gate replica
        st_d.gate_rep = gate_s;
    end

    // Reset blanks the channels and passes a blanking gate on
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= '0;
            st_q.gate_rep <= GATE_RST;
            st_q.strobe_rep <= STROBE_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign strobe_repeat = st_q.strobe_rep;
    assign gate_repeat_n = st_q.gate_rep;
    assign current_sink_channels = st_q.chan;

    ////////////////////////////////////////////////////////////////////////
    // Checks, system domain

    // [R1] Gate high blanks
    gate_blank_a: assert property (@(posedge clk) disable iff (rst) // [R1]
        gate_s |=> current_sink_channels == '0)
        else $error("channels lit while gate high");

    // [R1] Reset blanks and passes a blanking gate on
    rst_values_a: assert property (@(posedge clk) // [R1]
        rst |=> gate_repeat_n && !strobe_repeat
            && current_sink_channels == '0)
        else $error("outputs wrong after reset");

    // [R11] Channels show latch when enabled
    chan_value_a: assert property (@(posedge clk) disable iff (rst) // [R11]
        !gate_s |=> current_sink_channels == $past(st_q.latch[CHAN_NUM-1:0]))
        else $error("channel differs from latch");

    // [R3] Latch holds without strobe and with no word queued
    latch_hold_a: assert property (@(posedge clk) disable iff (rst) // [R3]
        (!strobe_s && !pop_valid) [*2] |-> $stable(st_q.latch))
        else $error("latch moved while strobe low");

    // [R3] Stalled latch stays put
    hold_stall_a: assert property (@(posedge clk) disable iff (rst) // [R3]
        latch_hold |=> $stable(st_q.latch))
        else $error("latch moved during stall");

    // [R3] No word taken while strobe low
    sent_hold_a: assert property (@(posedge clk) disable iff (rst) // [R3]
        !strobe_s |=> $stable(st_q.sent))
        else $error("word taken while strobe low");

    // [R2] Stable new word reaches latch when nothing stalls
    latch_follow_a: assert property (@(posedge clk) disable iff (rst) // [R2]
        (push_valid && !pop_valid && !latch_hold) ##1 !latch_hold
        |=> st_q.latch == $past(word_s, 2))
        else $error("latch did not follow word");

    // [R2] Latch changes only by a drained word
    latch_src_a: assert property (@(posedge clk) disable iff (rst) // [R2]
        $changed(st_q.latch) |-> $past(pop_valid && pop_ready))
        else $error("latch changed without a word");

    // [R12] Offered word has held still
    word_settle_a: assert property (@(posedge clk) disable iff (rst) // [R12]
        push_valid |-> $stable(word_s) && st_q.stab == STAB_MAX)
        else $error("unsettled word offered");

    // [R9] Strobe replica one cycle behind
    strobe_copy_a: assert property (@(posedge clk) disable iff (rst) // [R9]
        ##1 strobe_repeat == $past(strobe_s))
        else $error("strobe repeat wrong");

    // [R10] Gate replica one cycle behind
    gate_copy_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        ##1 gate_repeat_n == $past(gate_s))
        else $error("gate repeat wrong");

    ////////////////////////////////////////////////////////////////////////
    // Checks, link domain

    // [R4] One place per rising edge
    // [R5] Serial input enters at bit zero
    shift_step_a: assert property (@(posedge link_clk) // [R4]
        disable iff (lrst)
        !lrst |=> sr_q == {$past(sr_q[SR_LEN-2:0]), $past(serial_in)})
        else $error("shift register step wrong");

    // [R4] Link reset clears the register
    sr_rst_a: assert property (@(posedge link_clk) // [R4]
        lrst |=> sr_q == '0)
        else $error("shift register not cleared");

    // [R6] Output takes top bit at the falling edge
    sout_fall_a: assert property (@(negedge link_clk) // [R6]
        disable iff (lrst)
        !lrst |=> serial_out == $past(sr_q[SR_LEN-1]))
        else $error("serial out not from falling edge");

    // [R6] At a rising edge the output still shows the top bit,
    // so it did not move on that edge
    sout_steady_a: assert property (@(posedge link_clk) // [R6]
        disable iff (lrst)
        !lrst |-> serial_out == sr_q[SR_LEN-1])
        else $error("serial out moved on rising edge");

    // [R6] Link reset parks the output low
    serial_rst_a: assert property (@(negedge link_clk) // [R6]
        lrst |=> !serial_out)
        else $error("serial out not low in reset");

    // [R8] Replica high before each falling edge
    clk_high_a: assert property (@(negedge link_clk) // [R8]
        disable iff (lrst)
        !lrst ##1 !lrst |-> clock_repeat)
        else $error("clock repeat low in high phase");

    // [R8] Replica low before each rising edge
    clk_low_a: assert property (@(posedge link_clk) // [R8]
        disable iff (lrst)
        !lrst |-> !clock_repeat)
        else $error("clock repeat high in low phase");

    // [R8] Link reset holds the replica low
    clk_rst_a: assert property (@(posedge link_clk) // [R8]
        lrst |=> !clock_repeat)
        else $error("clock repeat high in reset");
endmodule

// [rtl/clsl_pkg.sv]
// Purpose: Shared constants of the cascaded LED shift and latch block
// Assumes: System clock of 100 MHz, serial link clock of up to 5 MHz
// Notes: Counts of cycles are derived from the times, never typed in
package clsl_pkg;
    // Shift register length and channel count
    localparam int SR_LEN_DEF = 3;
    localparam int CHAN_NUM = 3;
    // System clock period and fastest link clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_MAX_KHZ = 5000;
    localparam int LINK_PERIOD_NS = 1000000 / LINK_MAX_KHZ;
    // Word must hold still this long before it is trusted
    localparam int STABLE_NS = LINK_PERIOD_NS / 2;
    localparam int STABLE_CYC =
        (STABLE_NS / CLK_PERIOD_NS) < 1 ? 1 : STABLE_NS / CLK_PERIOD_NS;
    localparam int STAB_W = $clog2(STABLE_CYC + 1);
    // Values after reset
    localparam logic GATE_RST = 1'b1;
    localparam logic STROBE_RST = 1'b0;
endpackage

// [rtl/clsl_sync.sv]
// Purpose: Two flip-flop synchroniser for a group of quasi-static bits
// Assumes: Each bit is a level; a bus is only used after a stability check
// Notes: First stage feeds the second stage and nothing else
`timescale 1ns/1ps
module clsl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Two stages, synchronous reset to a constant
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

// [rtl/clsl_buf.sv]
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: One clock; push and pop may happen in the same cycle
// Notes: Full blocks the source, so a stalled drain loses nothing
`timescale 1ns/1ps
module clsl_buf #(
    parameter int W = 3,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != FULL_CNT);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap at the depth, count tracks fill
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end

    // Storage needs no reset, valid is guarded by the count
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// [tb/clsl_master.sv]
// Purpose: Behavioural upstream controller on the link side
// Assumes: Link clock stands still low between frames
// Notes: A released data line shows the inverse of its last bit
`timescale 1ns/1ps
module clsl_master (
    output logic link_clk,
    output logic serial_in
);
    ////////////////////////////////////////////////////////////////
    // Idle levels at time zero
    initial
    begin
        link_clk = 1'b0;
        serial_in = 1'b0;
    end

    // Shift n bits, top bit first, 6 ns link period
    task automatic shift_bits(input logic [7:0] b, input int n);
        // Off phase from the system clock
        #1.3;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in = b[i];
            #3 link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
        // No pull on the line, so the old bit must not linger
        serial_in = ~serial_in;
    endtask
endmodule

// [tb/clsl_top_tb.sv]
// Purpose: Self-checking bench of the LED shift and latch block
// Assumes: Link clock runs only during frames and reset
// Notes: Latch expectations come from a reference word kept here
`timescale 1ns/1ps
module clsl_top_tb
    import clsl_pkg::*;
;
    localparam int SRL = 3;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic latch_strobe = 1'b0;
    logic gate_n = 1'b0;
    logic latch_hold = 1'b0;
    logic link_clk, serial_in, serial_out, clock_repeat;
    logic strobe_repeat, gate_repeat_n;
    logic [CHAN_NUM-1:0] current_sink_channels, lat, w;
    logic [7:0] hist = '0;
    logic [2:0] sh = '0;
    logic [2:0] gh = '1;
    logic link_chk = 1'b0;
    int seed = 32'h5a887c21;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int up = 0;

    ////////////////////////////////////////////////////////////////
    clsl_master m_u (.link_clk(link_clk), .serial_in(serial_in));
    clsl_top #(.SR_LEN(SRL)) dut_u (
        .clk(clk),
        .rst(rst),
        .link_clk(link_clk),
        .serial_in(serial_in),
        .latch_strobe(latch_strobe),
        .gate_n(gate_n),
        .latch_hold(latch_hold),
        .serial_out(serial_out),
        .clock_repeat(clock_repeat),
        .strobe_repeat(strobe_repeat),
        .gate_repeat_n(gate_repeat_n),
        .current_sink_channels(current_sink_channels)
    );

    // System clock, 100 MHz
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input logic [CHAN_NUM-1:0] e);
        n_tests++;
        if (current_sink_channels !== e)
        begin
            fails++;
            $display("unexpected channels expected %b seen %b", e,
                current_sink_channels);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic shift(input logic [2:0] v);
        m_u.shift_bits({5'h00, v}, SRL);
    endtask

    // Shift with strobe low, then one strobe pulse
    task automatic load(input logic [2:0] v);
        shift(v);
        @(posedge clk) latch_strobe <= 1'b1;
        wait_clk(30);
        latch_strobe <= 1'b0;
        wait_clk(25);
        lat = v;
    endtask

    ////////////////////////////////////////////////////////////////
    // Chain output: bit seen SRL rises after it went in
    always @(posedge link_clk)
    begin
        if (link_chk)
            chk_bit("serial_out", hist[SRL-1], serial_out);
        hist <= {hist[6:0], serial_in};
    end

    // Clock replica follows each link edge
    always @(link_clk)
        if (link_chk)
        begin
            #1;
            chk_bit("clock_repeat", link_clk, clock_repeat);
        end

    // Replica pins trail their inputs by three clk; also the watchdog
    always @(posedge clk)
    begin
        sh <= {sh[1:0], latch_strobe};
        gh <= {gh[1:0], gate_n};
        up <= rst ? 0 : up + 1;
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            fails++;
            print_verdict();
        end
    end

    always @(negedge clk)
        if (up > 4)
        begin
            chk_bit("strobe_repeat", sh[2], strobe_repeat);
            chk_bit("gate_repeat_n", gh[2], gate_repeat_n);
        end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        lat = '0;
        fork
            m_u.shift_bits(8'h5a, 8);
            wait_clk(20);
        join
        rst <= 1'b0;
        wait_clk(2);
        m_u.shift_bits(8'h00, 4);
        shift(3'h0);
        link_chk = 1'b1;
        // Every code, then random words
        for (int i = 0; i < 12; i++)
        begin
            w = (i < 8) ? 3'(i) : 3'($random(seed));
            load(w);
            chk_word(lat);
        end
        // Strobe low holds the latch
        shift(~lat);
        wait_clk(25);
        chk_word(lat);
        // Strobe high lets new bits through
        @(posedge clk) latch_strobe <= 1'b1;
        wait_clk(2);
        w = 3'($random(seed));
        shift(w);
        wait_clk(30);
        chk_word(w);
        latch_strobe <= 1'b0;
        lat = w;
        wait_clk(20);
        // Gate blanks and restores
        gate_n <= 1'b1;
        wait_clk(10);
        chk_word('0);
        gate_n <= 1'b0;
        wait_clk(10);
        chk_word(lat);
        // Stall the latch while three words arrive, then drain
        latch_hold <= 1'b1;
        latch_strobe <= 1'b1;
        for (int k = 1; k < 4; k++)
        begin
            shift(lat ^ 3'(k));
            wait_clk(20);
            chk_word(lat);
        end
        latch_hold <= 1'b0;
        wait_clk(40);
        lat = lat ^ 3'h3;
        latch_strobe <= 1'b0;
        wait_clk(10);
        chk_word(lat);
        print_verdict();
    end
endmodule
